//--- verilog/t1im_pkg.sv
package t1im_pkg;

  // parallel register port
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam logic [4:0] RESET_CTRL_ADDR = 5'h1a;
  localparam logic [4:0] MASK_WORD0_ADDR = 5'h1b;
  localparam logic [4:0] MASK_WORD1_ADDR = 5'h1c;
  localparam logic [4:0] MASK_WORD2_ADDR = 5'h1d;

  // reset control word bits handled here
  localparam int SUSPEND_BIT = 6;
  localparam int ACK_BIT = 5;

  // writable bits of each mask word
  localparam logic [7:0] MASK0_USED = 8'hdf;
  localparam logic [7:0] MASK1_USED = 8'hfe;
  localparam logic [7:0] MASK2_USED = 8'hff;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // status vector layout: word0 at [7:0], word1 at [15:8], word2 at [23:16]
  localparam int EV_W = 24;
  localparam int EV_TERM_SYNC = 7;
  localparam int EV_MF_SYNC = 6;
  localparam int EV_ALL_ONES = 4;
  localparam int EV_SIG_LOSS = 3;
  localparam int EV_SEF = 2;
  localparam int EV_TX_SLIP = 1;
  localparam int EV_RX_SLIP = 0;
  localparam int EV_FBIT_ERR = 15;
  localparam int EV_CRC6 = 14;
  localparam int EV_YELLOW = 13;
  localparam int EV_REALIGN = 12;
  localparam int EV_BPV = 11;
  localparam int EV_PRBS = 10;
  localparam int EV_PDV = 9;
  localparam int EV_WRAP_LSB = 16;
  localparam int WRAP_N = 8;

  // counter wrap points
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_ZERO = 8'h00;

  // vector codes
  localparam logic [7:0] VEC_SIG_LOSS = 8'h40;
  localparam logic [7:0] VEC_NONE = 8'h00;

  // severely errored frame: two errors in this many framing bits
  localparam int SEF_WINDOW = 6;

  // bus synchroniser: strobes idle high
  localparam int SYNC_W = 16;
  localparam logic [15:0] SYNC_RESET = 16'he000;

  typedef enum logic [1:0] {T1IM_SEL_CTRL, T1IM_SEL_MASK0, T1IM_SEL_MASK1, T1IM_SEL_MASK2} t1im_sel_t;

endpackage : t1im_pkg

//--- verilog/t1im_sync.sv
`timescale 1ns/100ps
module t1im_sync
  import t1im_pkg::*;
#(
  parameter int W = SYNC_W,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // asynchronous pins and agreed levels
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);

  logic [W-1:0] ff1;
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;

  always_ff @(posedge clk) begin
    if (rst) begin
      ff1 <= RST_VAL;
      ff2 <= RST_VAL;
      ff3 <= RST_VAL;
    end else begin
      ff1 <= pin;
      ff2 <= ff1;
      ff3 <= ff2;
    end
  end

  // a bit only moves once the second and third stages agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          level[i] <= RST_VAL[i];
        end else if (ff2[i] == ff3[i]) begin
          level[i] <= ff3[i];
        end
      end
    end
  endgenerate

endmodule : t1im_sync

//--- verilog/t1im_wrap_det.sv
`timescale 1ns/100ps
module t1im_wrap_det
  import t1im_pkg::*;
#(
  parameter int N = WRAP_N
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // counter values, counter 0 in the low byte
  input wire logic [8*N-1:0] cnt,
  // one-cycle wrap pulses
  output logic [N-1:0] wrap
);

  logic [8*N-1:0] prev;

  always_ff @(posedge clk) begin
    if (rst) begin
      prev <= '0;
    end else begin
      prev <= cnt;
    end
  end

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_cnt
      assign wrap[i] = (prev[8*i +: 8] == CNT_MAX) && (cnt[8*i +: 8] == CNT_ZERO);
    end
  endgenerate

endmodule : t1im_wrap_det

//--- verilog/t1im_mask_ctl.sv
`timescale 1ns/100ps
// What this block does
// - mask one passes event, zero blocks it
// - word0 bit7: any terminal sync change interrupts
// - word0 bit6: any multiframe sync change interrupts
// - word0 bit4: all-ones alarm start/end interrupts
// - word0 bit3: loss-of-signal change, vector 01000000
// - word0 bit2: two framing errors in six
// - word0 bits1,0: transmit and receive slips
// - word1 bit7: framing bit error, only in sync
// - word1 bit6: local CRC-6 failure interrupts
// - word1 bit5: received yellow alarm interrupts
// - word1 bit4: reframe moved alignment interrupts
// - word1 bit3: bipolar violation, B8ZS codes excluded
// - word1 bit2: test pattern bit error interrupts
// - word1 bit1: pulse density violation interrupts
// - word2 bits7-2: six counters wrapping FFH to 00H
// - word2 bit1: test multiframe counter wrap interrupts
// - word2 bit0: multiframe unsync counter wrap interrupts
// - acknowledge clears status, releases request, self-clears
// - suspend floats request and ignores all sources
module t1im_mask_ctl
  import t1im_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // parallel register port
  input wire logic bus_cs_n,
  input wire logic bus_rd_n,
  input wire logic bus_wr_n,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [DATA_W-1:0] bus_wdata,
  output logic [DATA_W-1:0] bus_rdata,
  output logic bus_rdata_oe,
  // open-drain interrupt request
  output logic irq_n_o,
  output logic irq_n_oe,
  // alarm and sync levels
  input wire logic term_sync,
  input wire logic mf_sync,
  input wire logic all_ones,
  input wire logic sig_loss,
  input wire logic yellow_alarm,
  // event pulses
  input wire logic fbit_strobe,
  input wire logic fbit_err,
  input wire logic tx_slip,
  input wire logic rx_slip,
  input wire logic crc6_err,
  input wire logic realign_moved,
  input wire logic bpv,
  input wire logic bpv_b8zs,
  input wire logic prbs_err,
  input wire logic pdv,
  // error counters
  input wire logic [7:0] cnt_fbit,
  input wire logic [7:0] cnt_crc6,
  input wire logic [7:0] cnt_oof,
  input wire logic [7:0] cnt_cofa,
  input wire logic [7:0] cnt_bpv,
  input wire logic [7:0] cnt_prbs,
  input wire logic [7:0] cnt_prbs_mf,
  input wire logic [7:0] cnt_mf_oof,
  // status view
  output logic [EV_W-1:0] int_status,
  output logic [7:0] int_vector
);

  // address decode shared by reads and writes
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, output t1im_sel_t sel);
    addr_hit = 1'b1;
    sel = T1IM_SEL_CTRL;
    case (a)
      RESET_CTRL_ADDR: sel = T1IM_SEL_CTRL;
      MASK_WORD0_ADDR: sel = T1IM_SEL_MASK0;
      MASK_WORD1_ADDR: sel = T1IM_SEL_MASK1;
      MASK_WORD2_ADDR: sel = T1IM_SEL_MASK2;
      default: addr_hit = 1'b0;
    endcase
  endfunction : addr_hit

  // synchronised bus pins
  logic [SYNC_W-1:0] bus_lvl;
  logic cs_act;
  logic rd_act;
  logic wr_act;
  logic wr_act_d;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] wdata_s;
  logic wr_take;
  t1im_sel_t wr_sel;
  t1im_sel_t rd_sel;
  logic wr_hit;
  logic rd_hit;

  t1im_sync #(.W(SYNC_W), .RST_VAL(SYNC_RESET)) u_sync (
    .clk(clk),
    .rst(rst),
    .pin({bus_cs_n, bus_rd_n, bus_wr_n, bus_addr, bus_wdata}),
    .level(bus_lvl)
  );

  assign cs_act = ~bus_lvl[15];
  assign rd_act = ~bus_lvl[14] & cs_act;
  assign wr_act = ~bus_lvl[13] & cs_act;
  assign addr_s = bus_lvl[12:8];
  assign wdata_s = bus_lvl[7:0];
  // one write per strobe, taken as it opens
  assign wr_take = wr_act & ~wr_act_d;

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_act_d <= 1'b0;
    end else begin
      wr_act_d <= wr_act;
    end
  end

  always_comb begin
    wr_hit = addr_hit(addr_s, wr_sel);
    rd_hit = addr_hit(addr_s, rd_sel);
  end

  // control and mask registers
  logic [7:0] mask0;
  logic [7:0] mask1;
  logic [7:0] mask2;
  logic [EV_W-1:0] mask_all;
  logic suspend;
  logic ack;

  always_ff @(posedge clk) begin
    if (rst) begin
      mask0 <= MASK_RESET;
      mask1 <= MASK_RESET;
      mask2 <= MASK_RESET;
    end else if (wr_take && wr_hit) begin
      case (wr_sel)
        T1IM_SEL_MASK0: mask0 <= wdata_s & MASK0_USED;
        T1IM_SEL_MASK1: mask1 <= wdata_s & MASK1_USED;
        T1IM_SEL_MASK2: mask2 <= wdata_s & MASK2_USED;
        default: ;
      endcase
    end
  end

  assign mask_all = {mask2, mask1, mask0};

  always_ff @(posedge clk) begin
    if (rst) begin
      suspend <= 1'b0;
    end else if (wr_take && wr_hit && wr_sel == T1IM_SEL_CTRL) begin
      suspend <= wdata_s[SUSPEND_BIT];
    end
  end

  // acknowledge lives one cycle, then clears itself
  always_ff @(posedge clk) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= wr_take && wr_hit && wr_sel == T1IM_SEL_CTRL && wdata_s[ACK_BIT];
    end
  end

  // read port, data from a register
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    if (rd_act && rd_hit) begin
      case (rd_sel)
        T1IM_SEL_CTRL: begin
          next_rdata[SUSPEND_BIT] = suspend;
          next_rdata[ACK_BIT] = ack;
        end
        T1IM_SEL_MASK0: next_rdata = mask0;
        T1IM_SEL_MASK1: next_rdata = mask1;
        T1IM_SEL_MASK2: next_rdata = mask2;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus_rdata <= 8'h00;
      bus_rdata_oe <= 1'b0;
    end else begin
      bus_rdata <= next_rdata;
      bus_rdata_oe <= rd_act;
    end
  end

  // level-change detection; armed skips the first cycle so reset values do not fire
  logic armed;
  logic [4:0] lvl_prev;
  logic [4:0] lvl_now;

  assign lvl_now = {term_sync, mf_sync, all_ones, sig_loss, yellow_alarm};

  always_ff @(posedge clk) begin
    if (rst) begin
      armed <= 1'b0;
      lvl_prev <= 5'h00;
    end else begin
      armed <= 1'b1;
      lvl_prev <= lvl_now;
    end
  end

  // severely errored frame history, one bit per framing bit
  logic [SEF_WINDOW-2:0] fbit_hist;
  logic sef;

  always_ff @(posedge clk) begin
    if (rst) begin
      fbit_hist <= '0;
    end else if (fbit_strobe) begin
      fbit_hist <= {fbit_hist[SEF_WINDOW-3:0], fbit_err};
    end
  end

  assign sef = fbit_strobe & fbit_err & (|fbit_hist);

  // counter wraps, bit order matches mask word two
  logic [WRAP_N-1:0] wraps;

  t1im_wrap_det #(.N(WRAP_N)) u_wrap (
    .clk(clk),
    .rst(rst),
    .cnt({cnt_fbit, cnt_crc6, cnt_oof, cnt_cofa, cnt_bpv, cnt_prbs, cnt_prbs_mf, cnt_mf_oof}),
    .wrap(wraps)
  );

  // raw events
  logic [EV_W-1:0] events;

  always_comb begin
    events = '0;
    events[EV_TERM_SYNC] = armed & (lvl_prev[4] ^ term_sync);
    events[EV_MF_SYNC] = armed & (lvl_prev[3] ^ mf_sync);
    events[EV_ALL_ONES] = armed & (lvl_prev[2] ^ all_ones);
    events[EV_SIG_LOSS] = armed & (lvl_prev[1] ^ sig_loss);
    events[EV_SEF] = sef;
    events[EV_TX_SLIP] = tx_slip;
    events[EV_RX_SLIP] = rx_slip;
    events[EV_FBIT_ERR] = fbit_err & term_sync;
    events[EV_CRC6] = crc6_err;
    events[EV_YELLOW] = armed & ~lvl_prev[0] & yellow_alarm;
    events[EV_REALIGN] = realign_moved;
    events[EV_BPV] = bpv & ~bpv_b8zs;
    events[EV_PRBS] = prbs_err;
    events[EV_PDV] = pdv;
    events[EV_W-1:EV_WRAP_LSB] = wraps;
  end

  // sticky status; a new event beats a same-cycle acknowledge
  always_ff @(posedge clk) begin
    if (rst) begin
      int_status <= '0;
    end else if (suspend) begin
      int_status <= ack ? '0 : int_status;
    end else if (ack) begin
      int_status <= events;
    end else begin
      int_status <= int_status | events;
    end
  end

  // request and vector, both registered
  logic irq_drive;
  logic [EV_W-1:0] live;

  assign live = int_status & mask_all;

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_drive <= 1'b0;
      int_vector <= VEC_NONE;
    end else begin
      irq_drive <= (|live) & ~suspend & ~ack;
      int_vector <= live[EV_SIG_LOSS] ? VEC_SIG_LOSS : VEC_NONE;
    end
  end

  // pin pulls low only; released means high impedance
  assign irq_n_o = 1'b0;
  assign irq_n_oe = irq_drive;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_mask_gate;
    !ack && !suspend && !$past(ack) |-> ##1 (irq_n_oe == ((|$past(live)) ));
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("request does not follow masked status");

  property p_term_sync;
    $changed(term_sync) && armed && !suspend |=> int_status[EV_TERM_SYNC];
  endproperty
  a_term_sync: assert property (p_term_sync) else $error("terminal sync change not latched");

  property p_mf_sync;
    $changed(mf_sync) && armed && !suspend |=> int_status[EV_MF_SYNC];
  endproperty
  a_mf_sync: assert property (p_mf_sync) else $error("multiframe sync change not latched");

  property p_los_vector;
    $changed(sig_loss) && armed && !suspend && mask0[EV_SIG_LOSS] && wr_take == 1'b0 |=> ##1 int_vector == VEC_SIG_LOSS;
  endproperty
  a_los_vector: assert property (p_los_vector) else $error("loss of signal vector missing");

  property p_sef;
    $rose(int_status[EV_SEF]) |-> $past(fbit_strobe && fbit_err && (|fbit_hist));
  endproperty
  a_sef: assert property (p_sef) else $error("severe frame error without two errors in window");

  property p_fbit_in_sync;
    $rose(int_status[EV_FBIT_ERR]) |-> $past(fbit_err && term_sync);
  endproperty
  a_fbit_in_sync: assert property (p_fbit_in_sync) else $error("framing error latched out of sync");

  property p_bpv_b8zs;
    $rose(int_status[EV_BPV]) |-> $past(bpv && !bpv_b8zs);
  endproperty
  a_bpv_b8zs: assert property (p_bpv_b8zs) else $error("substitution code counted as violation");

  property p_wrap;
    $past(cnt_fbit) == CNT_MAX && cnt_fbit == CNT_ZERO && !suspend |=> int_status[EV_W-1];
  endproperty
  a_wrap: assert property (p_wrap) else $error("framing counter wrap not latched");

  sequence s_ack_write;
    wr_take && wr_hit && wr_sel == T1IM_SEL_CTRL && wdata_s[ACK_BIT];
  endsequence

  sequence s_ack_done;
    ack ##1 (!ack && !irq_n_oe && ((int_status & ~$past(events)) == '0));
  endsequence

  property p_ack;
    s_ack_write |=> s_ack_done;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge did not clear and release");

  property p_suspend;
    suspend |=> !irq_n_oe;
  endproperty
  a_suspend: assert property (p_suspend) else $error("request driven while suspended");

  property p_unused;
    !mask0[5] && !mask1[0];
  endproperty
  a_unused: assert property (p_unused) else $error("unused mask bit holds a one");

endmodule : t1im_mask_ctl

//--- test/t1im_host.sv
`timescale 1ns/100ps
module t1im_host
  import t1im_pkg::*;
(
  // clock
  input wire logic clk,
  // parallel register port
  output logic bus_cs_n,
  output logic bus_rd_n,
  output logic bus_wr_n,
  output logic [ADDR_W-1:0] bus_addr,
  output logic [DATA_W-1:0] bus_wdata,
  input wire logic [DATA_W-1:0] bus_rdata,
  input wire logic bus_rdata_oe
);
  initial begin
    bus_cs_n = 1'b1;
    bus_rd_n = 1'b1;
    bus_wr_n = 1'b1;
    bus_addr = '0;
    bus_wdata = '0;
  end

  // strobes low for hold clocks, then high 7 clocks; hold of 7 or more covers read latency
  task automatic access(input logic is_wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      input int hold, output logic [DATA_W-1:0] q, output logic q_oe);
    @(posedge clk);
    bus_cs_n <= 1'b0;
    bus_wr_n <= ~is_wr;
    bus_rd_n <= is_wr;
    bus_addr <= a;
    bus_wdata <= d;
    repeat (hold) @(posedge clk);
    q = bus_rdata;
    q_oe = bus_rdata_oe;
    bus_cs_n <= 1'b1;
    bus_wr_n <= 1'b1;
    bus_rd_n <= 1'b1;
    // released lines must not keep the last value
    bus_addr <= ~a;
    bus_wdata <= ~d;
    repeat (7) @(posedge clk);
  endtask : access
endmodule : t1im_host

//--- test/tb_t1im_mask_ctl.sv
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_t1im_mask_ctl
  import t1im_pkg::*;
;
  int num_errors = 0;
  int checked = 0;
  int seed = 23058;
  logic clk = 1'b0;
  logic rst;
  logic bus_cs_n, bus_rd_n, bus_wr_n, bus_rdata_oe, irq_n_o, irq_n_oe;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_wdata, bus_rdata, d;
  logic term_sync, mf_sync, all_ones, sig_loss, yellow_alarm, fbit_strobe, fbit_err, tx_slip, rx_slip;
  logic crc6_err, realign_moved, bpv, bpv_b8zs, prbs_err, pdv;
  logic [7:0] cnt [8];
  logic [EV_W-1:0] int_status;
  logic [7:0] int_vector;
  logic [7:0] used [3] = '{MASK0_USED, MASK1_USED, MASK2_USED};

  always #20 clk = ~clk;

  t1im_host host_inst (.clk(clk), .bus_cs_n(bus_cs_n), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rdata_oe(bus_rdata_oe));

  t1im_mask_ctl t1im_mask_ctl_inst (.clk(clk), .rst(rst), .bus_cs_n(bus_cs_n), .bus_rd_n(bus_rd_n),
    .bus_wr_n(bus_wr_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_rdata_oe(bus_rdata_oe), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .term_sync(term_sync),
    .mf_sync(mf_sync), .all_ones(all_ones), .sig_loss(sig_loss), .yellow_alarm(yellow_alarm),
    .fbit_strobe(fbit_strobe), .fbit_err(fbit_err), .tx_slip(tx_slip), .rx_slip(rx_slip),
    .crc6_err(crc6_err), .realign_moved(realign_moved), .bpv(bpv), .bpv_b8zs(bpv_b8zs),
    .prbs_err(prbs_err), .pdv(pdv), .cnt_fbit(cnt[7]), .cnt_crc6(cnt[6]), .cnt_oof(cnt[5]),
    .cnt_cofa(cnt[4]), .cnt_bpv(cnt[3]), .cnt_prbs(cnt[2]), .cnt_prbs_mf(cnt[1]), .cnt_mf_oof(cnt[0]),
    .int_status(int_status), .int_vector(int_vector));

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] wd, output logic [7:0] q);
    logic oe;
    host_inst.access(w, a, wd, 7 + int'($unsigned($random(seed)) % 3), q, oe);
    if (!w && a >= RESET_CTRL_ADDR && a <= MASK_WORD2_ADDR) `CHK(oe, 1'b1)
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [7:0] wd);
    logic [7:0] q;
    bus(1'b1, a, wd, q);
  endtask : wr

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    `CHK(q, exp)
  endtask : rd_chk

  task automatic wr_mask(input logic [EV_W-1:0] m);
    wr(MASK_WORD0_ADDR, m[7:0]);
    wr(MASK_WORD1_ADDR, m[15:8]);
    wr(MASK_WORD2_ADDR, m[23:16]);
  endtask : wr_mask

  task automatic fstrobe(input logic e);
    fbit_strobe <= 1'b1;
    fbit_err <= e;
    @(posedge clk);
    fbit_strobe <= 1'b0;
    fbit_err <= 1'b0;
    @(posedge clk);
  endtask : fstrobe

  task automatic fire(input int i, input logic neg);
    @(posedge clk);
    case (i)
      EV_TERM_SYNC: term_sync <= ~term_sync;
      EV_MF_SYNC: mf_sync <= ~mf_sync;
      EV_ALL_ONES: all_ones <= ~all_ones;
      EV_SIG_LOSS: sig_loss <= ~sig_loss;
      EV_SEF: begin
        repeat (5) fstrobe(1'b0);
        fstrobe(1'b1);
        repeat (neg ? 5 : 4) fstrobe(1'b0);
        fstrobe(1'b1);
      end
      EV_TX_SLIP: tx_slip <= 1'b1;
      EV_RX_SLIP: rx_slip <= 1'b1;
      EV_FBIT_ERR: begin
        term_sync <= ~neg;
        repeat (3) @(posedge clk);
        fstrobe(1'b1);
      end
      EV_CRC6: crc6_err <= 1'b1;
      EV_YELLOW: begin
        yellow_alarm <= 1'b1;
        repeat (2) @(posedge clk);
        yellow_alarm <= 1'b0;
      end
      EV_REALIGN: realign_moved <= 1'b1;
      EV_BPV: begin
        bpv <= 1'b1;
        bpv_b8zs <= neg;
      end
      EV_PRBS: prbs_err <= 1'b1;
      EV_PDV: pdv <= 1'b1;
      default: begin
        cnt[i-EV_WRAP_LSB] <= CNT_MAX;
        @(posedge clk);
        cnt[i-EV_WRAP_LSB] <= CNT_ZERO;
      end
    endcase
    @(posedge clk);
    {tx_slip, rx_slip, crc6_err, realign_moved, bpv, bpv_b8zs, prbs_err, pdv} <= '0;
    repeat (3) @(posedge clk);
  endtask : fire

  task automatic run(input int i, input logic neg);
    logic [EV_W-1:0] m;
    m = '0;
    m[i] = 1'b1;
    fire(i, neg);
    `CHK(int_status[i], ~neg)
    `CHK(irq_n_oe, 1'b0)
    if (!neg) begin
      wr_mask(m);
      `CHK(irq_n_oe, 1'b1)
      `CHK(irq_n_o, 1'b0)
      `CHK(int_vector, (i == EV_SIG_LOSS) ? VEC_SIG_LOSS : VEC_NONE)
    end
    wr(RESET_CTRL_ADDR, 8'h01 << ACK_BIT);
    `CHK(int_status[i], 1'b0)
    `CHK(irq_n_oe, 1'b0)
    rd_chk(RESET_CTRL_ADDR, 8'h00);
    if (!neg) wr_mask('0);
  endtask : run

  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    term_sync = 1'b1;
    {mf_sync, all_ones, sig_loss, yellow_alarm, fbit_strobe, fbit_err, tx_slip, rx_slip} = '0;
    {crc6_err, realign_moved, bpv, bpv_b8zs, prbs_err, pdv} = '0;
    cnt = '{default: 8'h00};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int k = 0; k < 4; k++) rd_chk(5'(RESET_CTRL_ADDR + k), 8'h00);
    for (int k = 0; k < 6; k++) begin
      d = (k < 3) ? 8'hff : 8'($random(seed));
      wr(5'(MASK_WORD0_ADDR + k % 3), d);
      rd_chk(5'(MASK_WORD0_ADDR + k % 3), d & used[k % 3]);
    end
    // unmapped place: write dropped, read zero
    wr(5'h05, 8'hff);
    rd_chk(5'h05, 8'h00);
    wr_mask('0);
    // sync, all-ones and loss-of-signal sources run twice so both directions of change are seen
    for (int i = 0; i < EV_W; i++) begin
      if (i != 5 && i != 8) repeat ((i inside {3, 4, 6, 7}) ? 2 : 1) run(i, 1'b0);
    end
    run(EV_SEF, 1'b1);
    run(EV_BPV, 1'b1);
    run(EV_FBIT_ERR, 1'b1);
    // mask open before the change, so the vector follows the event itself
    wr_mask(24'h1 << EV_SIG_LOSS);
    fire(EV_SIG_LOSS, 1'b0);
    `CHK(irq_n_oe, 1'b1)
    `CHK(int_vector, VEC_SIG_LOSS)
    wr(RESET_CTRL_ADDR, 8'h01 << ACK_BIT);
    `CHK(int_vector, VEC_NONE)
    wr_mask(24'h1 << EV_REALIGN);
    wr(RESET_CTRL_ADDR, 8'h01 << SUSPEND_BIT);
    rd_chk(RESET_CTRL_ADDR, 8'h01 << SUSPEND_BIT);
    fire(EV_REALIGN, 1'b0);
    `CHK(int_status[EV_REALIGN], 1'b0)
    `CHK(irq_n_oe, 1'b0)
    wr(RESET_CTRL_ADDR, 8'h00);
    fire(EV_REALIGN, 1'b0);
    `CHK(irq_n_oe, 1'b1)
    wr(RESET_CTRL_ADDR, 8'h01 << SUSPEND_BIT);
    `CHK(irq_n_oe, 1'b0)
    tally_and_finish();
  end
endmodule : tb_t1im_mask_ctl
